// file: hdl/pfr_top.sv
// fast-lock timer, sigma-delta interpolator and phase resync control
// ************************************************************
// Overview of operation
// - divider mode 0,1 selects fast lock, timer loaded from clock divider times modulus
// - wide bandwidth held for count-derived comparison periods, then narrow again
// - charge pump gain is sixteen times normal during wide bandwidth
// - loop switch pin grounded during wide bandwidth in fast-lock mode
// - third-order sigma-delta interpolator, modulus any integer 2 to 4095
// - interpolator steps once per comparison cycle, step is rate over modulus
// - without dither code repeats after modulus-dependent length
// - with dither code repeats only after two to the 21 cycles
// - interpolator seeded with the phase word
// - divider mode 1,0 enables phase resynchronisation
// - resync timer pulses every clock divider times modulus comparison periods
// - clock divider is a 12-bit field, 1 to 4095
// - modulus is 12-bit field of word 1, used in sync interval
// - after a new frequency commit, realign phase on second sync pulse
// - phase word sets output phase linearly, 360 over modulus per step
// - 32 bits shifted on rising serial clock, latched when strobe rises
// ************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "pfr_consts.svh"
module pfr_top #(
  parameter int PFD_DIV = 1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic latch_load_strobe_i,
  output logic [15:0] int_value_o,
  output logic [3:0] frac_code_o,
  output logic pfd_en_o,
  output logic [11:0] fractional_modulus_o,
  output logic [11:0] phase_word_o,
  output logic dither_o,
  output logic [1:0] div_mode_o,
  output logic fast_lock_o,
  output logic [4:0] cp_gain_o,
  output logic loop_switch_pin_o,
  output logic sync_pulse_o,
  output logic phase_realign_o
);
  // ************************************************************
  // reset state and helpers
  // ************************************************************
  localparam pfr_pkg::pfr_state_s RST = '{
    fractional_modulus: `PFR_MOD_MIN,
    clk_div: `PFR_CDIV_MIN,
    div_mode: pfr_pkg::PFR_MODE_OFF,
    cp_gain: `PFR_CP_NORMAL,
    lfsr: `PFR_LFSR_SEED,
    default: '0
  };
  localparam logic [7:0] PFD_LAST = 8'(PFD_DIV - 1);

  pfr_pkg::pfr_state_s s_q;
  pfr_pkg::pfr_state_s s_d;

  // one modulo accumulator stage: {carry, residue}
  function automatic logic [12:0] pfr_acc(input logic [11:0] a, input logic [11:0] b,
                                          input logic [11:0] m);
    logic [12:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= {1'b0, m}) begin
      pfr_acc = {1'b1, 12'(sum - {1'b0, m})};
    end else begin
      pfr_acc = {1'b0, sum[11:0]};
    end
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    logic sclk_rise;
    logic le_rise;
    logic [12:0] r1;
    logic [12:0] r2;
    logic [12:0] r3;
    logic [11:0] in1;
    logic [11:0] wv;
    sclk_rise = 1'b0;
    le_rise = 1'b0;
    r1 = '0;
    r2 = '0;
    r3 = '0;
    in1 = '0;
    wv = '0;
    s_d = s_q;
    // pins pass two flops; the third stage only feeds edge detection
    s_d.sclk_s1 = ser_clk_i;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_s3 = s_q.sclk_s2;
    s_d.sdat_s1 = ser_data_i;
    s_d.sdat_s2 = s_q.sdat_s1;
    s_d.le_s1 = latch_load_strobe_i;
    s_d.le_s2 = s_q.le_s1;
    s_d.le_s3 = s_q.le_s2;
    sclk_rise = s_q.sclk_s2 & ~s_q.sclk_s3;
    le_rise = s_q.le_s2 & ~s_q.le_s3;

    // serial shift, msb first; data path delayed like the clock path
    if (sclk_rise) begin
      s_d.shreg = {s_q.shreg[30:0], s_q.sdat_s2};
    end
    // commit the addressed word on the strobe rising edge
    s_d.new_freq = 1'b0;
    if (le_rise) begin
      unique case (s_q.shreg[`PFR_ADDR_MSB:`PFR_ADDR_LSB])
        `PFR_ADDR_R0: begin
          s_d.int_val = s_q.shreg[`PFR_INT_MSB:`PFR_INT_LSB];
          s_d.frac = s_q.shreg[`PFR_FRAC_MSB:`PFR_FRAC_LSB];
          s_d.new_freq = 1'b1;
        end
        `PFR_ADDR_R1: begin
          s_d.phase = s_q.shreg[`PFR_PHASE_MSB:`PFR_PHASE_LSB];
          wv = s_q.shreg[`PFR_MOD_MSB:`PFR_MOD_LSB];
          // values below the legal floor would stall the accumulators
          s_d.fractional_modulus = (wv < `PFR_MOD_MIN) ? `PFR_MOD_MIN : wv;
        end
        `PFR_ADDR_R2: begin
          s_d.dither = (s_q.shreg[`PFR_DITH_MSB:`PFR_DITH_LSB] == `PFR_DITH_ON);
        end
        `PFR_ADDR_R3: begin
          s_d.div_mode = pfr_pkg::pfr_mode_e'(s_q.shreg[`PFR_DMODE_MSB:`PFR_DMODE_LSB]);
          wv = s_q.shreg[`PFR_CDIV_MSB:`PFR_CDIV_LSB];
          s_d.clk_div = (wv < `PFR_CDIV_MIN) ? `PFR_CDIV_MIN : wv;
        end
        default: begin
          // words for other latches belong to other blocks
        end
      endcase
    end

    // comparison-rate enable from the system clock
    if (s_q.pfd_cnt >= PFD_LAST) begin
      s_d.pfd_cnt = '0;
      s_d.pfd_en = 1'b1;
    end else begin
      s_d.pfd_cnt = s_q.pfd_cnt + 8'h01;
      s_d.pfd_en = 1'b0;
    end

    // shared interval: clock divider times modulus comparison periods
    s_d.period = {12'h000, s_q.clk_div} * {12'h000, s_q.fractional_modulus};

    // fast-lock timer; only mode 0,1 may start or hold it
    // gated on the incoming mode so the pin never shows wide bandwidth beside another mode
    if (s_d.div_mode != pfr_pkg::PFR_MODE_FASTLOCK) begin
      s_d.fast_lock = 1'b0;
      s_d.fl_cnt = '0;
    end else if (s_q.new_freq) begin
      s_d.fast_lock = 1'b1;
      s_d.fl_cnt = s_q.period;
    end else if (s_q.fast_lock && s_q.pfd_en) begin
      s_d.fl_cnt = s_q.fl_cnt - 24'h000001;
      if (s_q.fl_cnt <= 24'h000001) begin
        s_d.fast_lock = 1'b0;
      end
    end
    s_d.cp_gain = s_d.fast_lock ? `PFR_CP_BOOST : `PFR_CP_NORMAL;

    // periodic sync timer, running only in mode 1,0
    // incoming mode again: a tick may not leave in the cycle that idles the timer
    s_d.sync_pulse = 1'b0;
    s_d.realign = 1'b0;
    if (s_d.div_mode != pfr_pkg::PFR_MODE_RESYNC) begin
      s_d.sync_cnt = '0;
      s_d.armed = 1'b0;
      s_d.seen = 1'b0;
    end else begin
      if (s_q.pfd_en) begin
        if (s_q.sync_cnt + 24'h000001 >= s_q.period) begin
          s_d.sync_cnt = '0;
          s_d.sync_pulse = 1'b1;
        end else begin
          s_d.sync_cnt = s_q.sync_cnt + 24'h000001;
        end
      end
      // a new commit restarts the count even if a pulse lands with it
      if (s_q.new_freq) begin
        s_d.armed = 1'b1;
        s_d.seen = 1'b0;
      end else if (s_q.sync_pulse && s_q.armed) begin
        if (s_q.seen) begin
          s_d.realign = 1'b1;
          s_d.armed = 1'b0;
          s_d.seen = 1'b0;
        end else begin
          s_d.seen = 1'b1;
        end
      end
    end

    // dither source, 21-bit maximal sequence
    if (s_q.pfd_en) begin
      s_d.lfsr = {s_q.lfsr[19:0], s_q.lfsr[20] ^ s_q.lfsr[18]};
    end

    // three cascaded modulo accumulators with noise-shaping recombination
    in1 = s_q.dither ? 12'(s_q.frac + {11'h000, s_q.lfsr[0]}) : s_q.frac;
    r1 = pfr_acc(s_q.acc1, in1, s_q.fractional_modulus);
    r2 = pfr_acc(s_q.acc2, r1[11:0], s_q.fractional_modulus);
    r3 = pfr_acc(s_q.acc3, r2[11:0], s_q.fractional_modulus);
    if (s_q.new_freq || s_q.realign) begin
      // seed first stage with the phase word; it fixes the output phase
      s_d.acc1 = s_q.phase;
      s_d.acc2 = '0;
      s_d.acc3 = '0;
      s_d.c2_d = 1'b0;
      s_d.c3_d = 1'b0;
      s_d.c3_dd = 1'b0;
    end else if (s_q.pfd_en) begin
      s_d.acc1 = r1[11:0];
      s_d.acc2 = r2[11:0];
      s_d.acc3 = r3[11:0];
      s_d.c2_d = r2[12];
      s_d.c3_d = r3[12];
      s_d.c3_dd = s_q.c3_d;
      // repeat length follows from the modulo cycle of the stages
      s_d.code = {3'h0, r1[12]} + {3'h0, r2[12]} - {3'h0, s_q.c2_d}
                 + {3'h0, r3[12]} - {2'h0, s_q.c3_d, 1'b0} + {3'h0, s_q.c3_dd};
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs, all taken from state flops
  // ************************************************************
  assign int_value_o = s_q.int_val;
  assign frac_code_o = s_q.code;
  assign pfd_en_o = s_q.pfd_en;
  assign fractional_modulus_o = s_q.fractional_modulus;
  assign phase_word_o = s_q.phase;
  assign dither_o = s_q.dither;
  assign div_mode_o = s_q.div_mode;
  assign fast_lock_o = s_q.fast_lock;
  assign cp_gain_o = s_q.cp_gain;
  // switch closes to ground exactly while wide bandwidth is active
  assign loop_switch_pin_o = s_q.fast_lock;
  assign sync_pulse_o = s_q.sync_pulse;
  assign phase_realign_o = s_q.realign;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence commit_fl_s;
    s_q.new_freq && s_d.div_mode == pfr_pkg::PFR_MODE_FASTLOCK;
  endsequence
  sequence second_sync_s;
    s_q.sync_pulse && s_q.armed && s_q.seen && !s_q.new_freq &&
    s_d.div_mode == pfr_pkg::PFR_MODE_RESYNC;
  endsequence
  // the first tick after a commit only marks itself; it must not realign
  sequence first_sync_s;
    s_q.sync_pulse && s_q.armed && !s_q.seen;
  endsequence

  fl_load_a: assert property (commit_fl_s |=> fast_lock_o && s_q.fl_cnt == $past(s_q.period))
    else $error("fast lock not loaded from divider product");
  fl_end_a: assert property (
    fast_lock_o && s_q.fl_cnt == 24'h000001 && s_q.pfd_en && !s_q.new_freq |=> !fast_lock_o)
    else $error("fast lock did not end at count expiry");
  cp_gain_a: assert property (cp_gain_o == (fast_lock_o ? 5'h10 : 5'h01))
    else $error("charge pump gain wrong for bandwidth mode");
  sw_pin_a: assert property (loop_switch_pin_o |-> div_mode_o == 2'b01)
    else $error("loop switch grounded outside fast-lock mode");
  code_range_a: assert property ($signed(frac_code_o) >= -4'sd3 &&
                                 $signed(frac_code_o) <= 4'sd4)
    else $error("interpolator code out of range");
  seed_a: assert property (s_q.new_freq |=> s_q.acc1 == $past(s_q.phase))
    else $error("first stage not seeded with phase word");
  sync_mode_a: assert property (sync_pulse_o |-> div_mode_o == 2'b10)
    else $error("sync pulse outside resync mode");
  realign_a: assert property (second_sync_s |=> phase_realign_o ##1 !phase_realign_o)
    else $error("realign missing on second sync pulse");
  no_early_a: assert property (first_sync_s |=> !phase_realign_o)
    else $error("realign on first sync pulse");
  realign_seed_a: assert property (s_q.realign |=> s_q.acc1 == $past(s_q.phase))
    else $error("realign did not reseed with phase word");
  idle_a: assert property (div_mode_o == 2'b00 |=> !sync_pulse_o && !phase_realign_o)
    else $error("timer active in idle divider mode");
  word3_a: assert property (
    s_q.le_s2 && !s_q.le_s3 && s_q.shreg[2:0] == 3'h3 |=> div_mode_o == $past(s_q.shreg[16:15]))
    else $error("word 3 not committed on strobe rise");
  mod_floor_a: assert property (fractional_modulus_o >= 12'h002)
    else $error("modulus below two");
endmodule
`default_nettype wire

// file: hdl/pfr_consts.svh
// constants for the fractional-N synthesizer control block
`ifndef PFR_CONSTS_SVH
`define PFR_CONSTS_SVH
// ************************************************************
// serial word layout
// ************************************************************
`define PFR_WORD_BITS 32
`define PFR_ADDR_MSB 2
`define PFR_ADDR_LSB 0
`define PFR_ADDR_R0 3'h0
`define PFR_ADDR_R1 3'h1
`define PFR_ADDR_R2 3'h2
`define PFR_ADDR_R3 3'h3
// word 0: integer and fraction
`define PFR_INT_MSB 30
`define PFR_INT_LSB 15
`define PFR_FRAC_MSB 14
`define PFR_FRAC_LSB 3
// word 1: phase word and fractional modulus
`define PFR_PHASE_MSB 26
`define PFR_PHASE_LSB 15
`define PFR_MOD_MSB 14
`define PFR_MOD_LSB 3
// word 2: dither (low spur) select
`define PFR_DITH_MSB 30
`define PFR_DITH_LSB 29
`define PFR_DITH_ON 2'h3
// word 3: divider mode and clock divider value
`define PFR_DMODE_MSB 16
`define PFR_DMODE_LSB 15
`define PFR_CDIV_MSB 14
`define PFR_CDIV_LSB 3
// ************************************************************
// reset values and limits
// ************************************************************
`define PFR_MOD_MIN 12'h002
`define PFR_CDIV_MIN 12'h001
`define PFR_CP_NORMAL 5'h01
`define PFR_CP_BOOST 5'h10
`define PFR_LFSR_SEED 21'h000001
`endif

// file: hdl/pfr_pkg.sv
// types for the fractional-N synthesizer control block
package pfr_pkg;
  // divider mode field of word 3
  typedef enum logic [1:0] {
    PFR_MODE_OFF = 2'b00,
    PFR_MODE_FASTLOCK = 2'b01,
    PFR_MODE_RESYNC = 2'b10,
    PFR_MODE_RSVD = 2'b11
  } pfr_mode_e;
  // whole state of the block
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic sdat_s1;
    logic sdat_s2;
    logic le_s1;
    logic le_s2;
    logic le_s3;
    logic [31:0] shreg;
    logic [15:0] int_val;
    logic [11:0] frac;
    logic [11:0] fractional_modulus;
    logic [11:0] phase;
    pfr_mode_e div_mode;
    logic [11:0] clk_div;
    logic dither;
    logic new_freq;
    logic [7:0] pfd_cnt;
    logic pfd_en;
    logic [23:0] period;
    logic [23:0] fl_cnt;
    logic fast_lock;
    logic [4:0] cp_gain;
    logic [23:0] sync_cnt;
    logic sync_pulse;
    logic armed;
    logic seen;
    logic realign;
    logic [11:0] acc1;
    logic [11:0] acc2;
    logic [11:0] acc3;
    logic c2_d;
    logic c3_d;
    logic c3_dd;
    logic [3:0] code;
    logic [20:0] lfsr;
  } pfr_state_s;
endpackage

// file: testbench/pfr_host_model.sv
// host model that writes configuration words over the 3-wire serial link
`timescale 1ns/100ps
`default_nettype none
module pfr_host_model (
  input wire logic clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic latch_load_strobe_o
);
  // ****************
  // serial writer
  // ****************
  // idle levels before the first word
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    latch_load_strobe_o = 1'b0;
  end
  // msb first; ph sets the pace, the pins are resynchronised so ph stays >= 3
  task automatic put_word(input logic [31:0] w, input int ph);
    for (int i = 31; i >= 0; i--) begin
      @(negedge clk_i);
      ser_data_o = w[i];
      repeat (ph) @(negedge clk_i);
      ser_clk_o = 1'b1;
      repeat (ph) @(negedge clk_i);
      ser_clk_o = 1'b0;
      ser_data_o = ~w[i]; // a released line does not keep its last bit
    end
    latch_load_strobe_o = 1'b1;
    repeat (ph + 1) @(negedge clk_i);
    latch_load_strobe_o = 1'b0;
    repeat (ph + 1) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the fast-lock, interpolator and resync block
`timescale 1ns/100ps
`default_nettype none
`include "pfr_consts.svh"
module testbench;
  logic clk_i;
  logic sys_rst_i;
  wire logic sclk;
  wire logic sdat;
  wire logic lls;
  logic [15:0] iv;
  logic [3:0] code;
  logic [11:0] md;
  logic [11:0] ph;
  logic [1:0] dm;
  logic [4:0] cp;
  logic pfd, dth, fl, lsw, sp, ra;
  int fails = 0;
  int checks_done = 0;
  int seed = 3614;
  int bad = 0;
  int nsync = 0;
  int n;
  logic run = 1'b0;
  logic [15:0] iv_n = 16'h0100;
  logic [15:0] iv_q = 16'h0000;
  logic [3:0] cs[$];
  logic [3:0] old[$];
  int mods[5] = '{4, 9, 6, 5, 0};
  pfr_host_model u_host (.clk_i(clk_i), .ser_clk_o(sclk), .ser_data_o(sdat),
    .latch_load_strobe_o(lls));
  pfr_top #(.PFD_DIV(1)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ser_clk_i(sclk), .ser_data_i(sdat), .latch_load_strobe_i(lls),
    .int_value_o(iv), .frac_code_o(code), .pfd_en_o(pfd),
    .fractional_modulus_o(md), .phase_word_o(ph), .dither_o(dth),
    .div_mode_o(dm), .fast_lock_o(fl), .cp_gain_o(cp),
    .loop_switch_pin_o(lsw), .sync_pulse_o(sp), .phase_realign_o(ra));
  // ****************
  // helpers
  // ****************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // random pacing so both slow and brisk hosts are seen
  task automatic put(input logic [31:0] w);
    u_host.put_word(w, 3 + $unsigned($random(seed)) % 4);
  endtask
  task automatic put0();
    iv_n = iv_n + 16'h0001;
    put({1'b0, iv_n, 12'h001, 3'h0});
  endtask
  function automatic logic [31:0] w1(input logic [11:0] p, input logic [11:0] m);
    return {5'h00, p, m, 3'h1};
  endfunction
  function automatic logic [31:0] w3(input logic [1:0] o, input logic [11:0] c);
    return {15'h0000, o, c, 3'h3};
  endfunction
  task automatic wait_hi(ref logic s, input string t);
    for (int k = 0; k < 3000 && s !== 1'b1; k++) @(negedge clk_i);
    chk(t, 1, s);
  endtask
  task automatic grab(input int cnt);
    cs.delete();
    while (cs.size() < cnt) begin
      @(negedge clk_i);
      if (pfd === 1'b1) cs.push_back(code);
    end
  endtask
  // capture aligned to the commit; the reseed cycle keeps a stale code, so skip it
  task automatic put0_grab(input int cnt);
    fork
      put0();
      begin
        @(negedge clk_i);
        while (iv !== iv_n) @(negedge clk_i);
        @(negedge clk_i);
        grab(cnt);
      end
    join
  endtask
  // expected repeat length of the undithered code sequence
  function automatic int rlen(input int m);
    if (m % 6 == 0) return 6 * m;
    if (m % 3 == 0) return 3 * m;
    if (m % 2 == 0) return 2 * m;
    return m;
  endfunction
  // smallest period seen after a settling stretch, 0 when none up to lim
  function automatic int per(input int lim);
    int p;
    int i;
    for (p = 1; p <= lim; p++) begin
      for (i = lim; i < 2 * lim; i++) if (cs[i] !== cs[i + p]) break;
      if (i == 2 * lim) return p;
    end
    return 0;
  endfunction
  // ****************
  // clock, watchdog and per-cycle checks
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // about five times the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    test_done();
  end
  // realign count restarts when a new integer word lands
  always @(negedge clk_i) begin
    if (run) begin
      if (cp !== (fl ? `PFR_CP_BOOST : `PFR_CP_NORMAL) || lsw !== fl) bad++;
      if (dm[0] == dm[1] && (fl || sp || ra)) bad++;
      if (pfd !== 1'b1) bad++;
      nsync = (iv !== iv_q) ? 0 : nsync + int'(sp);
      iv_q = iv;
      if (ra === 1'b1) chk("syncs_before_realign", 2, nsync);
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    chk("reset_mod", 12'h002, md);
    chk("reset_fields", 0, {iv, ph, dm, fl});
    run = 1'b1;
    // power-up words in descending order, 5 and 4 are not ours
    put({$random(seed)} & 32'hfffffff8 | 32'h5);
    put({$random(seed)} & 32'hfffffff8 | 32'h4);
    chk("refused_addr", {12'h002, 2'h0}, {md, dm});
    put(w3(2'b01, 12'h002));
    put({1'b0, 2'h0, 26'h0000000, 3'h2});
    put(w1(12'h001, 12'h003));
    chk("mod_phase", {12'h003, 12'h001}, {md, ph});
    fork
      put0();
      begin
        wait_hi(fl, "fast_lock_rise");
        n = 0;
        while (fl === 1'b1 && n < 100) begin
          @(negedge clk_i);
          n++;
        end
        chk("fast_lock_len", 2 * 3, n);
      end
    join
    chk("int_word", iv_n, iv);
    // resync with a period of 5 x 4 comparison cycles
    put(w3(2'b10, 12'h005));
    chk("div_mode", 2'b10, dm);
    put(w1(12'h000, 12'h004));
    put0();
    wait_hi(ra, "realign");
    wait_hi(sp, "sync");
    n = 0;
    do begin
      @(negedge clk_i);
      n += int'(pfd);
    end while (sp !== 1'b1 && n < 200);
    chk("sync_gap", 5 * 4, n);
    // undithered repeat lengths, modes 00 and 11 idle
    mods[4] = 2 + $unsigned($random(seed)) % 40;
    foreach (mods[k]) begin
      put(w3(k[0] ? 2'b11 : 2'b00, 12'h001));
      put(w1(12'h000, mods[k][11:0]));
      put0();
      grab(3 * rlen(mods[k]));
      chk("repeat_len", rlen(mods[k]), per(rlen(mods[k])));
    end
    // a different seed word changes the pattern
    put(w1(12'h000, 12'h007));
    put0_grab(21);
    old = cs;
    put(w1(12'h003, 12'h007));
    put0_grab(21);
    chk("seeded_pattern", 1, old != cs);
    put({1'b0, `PFR_DITH_ON, 26'h0000000, 3'h2});
    put(w1(12'h000, 12'h032));
    put0();
    grab(600);
    chk("dither_on", 1, dth);
    chk("dither_period", 0, per(200));
    chk("cycle_checks", 0, bad);
    test_done();
  end
endmodule
`default_nettype wire
